// [dv/dar_seq_model.sv]
// sequencer-side model: apb master issuing the unit's register transfers
`default_nettype none
module dar_seq_model
    import dar_pkg::*;
(
    input wire logic sys_clk,
    output dar_apb_req_t req,
    input wire dar_apb_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rdata;
    logic rerr;
    initial begin
        req = '0;
        rdata = '0;
        rerr = 1'b0;
    end
    // ****************
    // one transfer, request held until pready is seen high
    // ****************
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= addr;
        req.pwdata <= data;
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (rsp.pready !== 1'b1);
        rdata = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // released address and data lines flip so stale values are never mistaken for held ones
        req.paddr <= ~addr;
        req.pwdata <= ~data;
    endtask : xfer
endmodule : dar_seq_model
`default_nettype wire

// [dv/dar_unit_tb_top.sv]
// self-checking bench for the double-integer and real arithmetic unit
`default_nettype none
module dar_unit_tb_top
    import dar_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    dar_apb_req_t apb_req;
    dar_apb_rsp_t apb_rsp;
    logic irq;
    int n_fail = 0;
    int total_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    dar_unit u_dar_unit (.sys_clk(sys_clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp), .irq(irq));
    dar_seq_model u_dar_seq_model (.sys_clk(sys_clk), .req(apb_req), .rsp(apb_rsp));
    // ****************
    // shared helpers
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_dar_seq_model.xfer(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
        u_dar_seq_model.xfer(1'b0, a, 32'h00000000);
        chk(u_dar_seq_model.rdata & m, exp);
    endtask : rdc
    task automatic irqchk(input logic exp);
        @(negedge sys_clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irqchk
    // block sum runs for count+1 cycles; poll busy with a bound
    task automatic waitsum;
        int i;
        for (i = 0; i < 400; i++) begin
            u_dar_seq_model.xfer(1'b0, OFF_FLAGS, 32'h00000000);
            if (u_dar_seq_model.rdata[3] === 1'b0) break;
        end
        chk({31'h0, u_dar_seq_model.rdata[3]}, 32'h00000000);
    endtask : waitsum
    task automatic fop(input logic [31:0] c, input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] d, input logic [31:0] f);
        wr(OFF_SRC1, a);
        wr(OFF_SRC2, b);
        wr(OFF_CMD, c);
        rdc(OFF_DEST, d);
        rdc(OFF_FLAGS, f, 32'h00000003);
    endtask : fop
    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        rdc(OFF_FLAGS, 32'h00000000);
        rdc(OFF_STS, 32'h00000000);
        rdc(OFF_DEST, 32'h00000000);
        irqchk(1'b0);
    endtask : t_reset
    task automatic t_sqrt;
        wr(OFF_SRC1, 32'h000143b8);
        wr(OFF_CMD, 32'h00000010);
        rdc(OFF_DEST, 32'h0000011f);
        rdc(OFF_FLAGS, 32'h00000004, 32'h00000005);
        wr(OFF_SRC1, 32'h00000000);
        wr(OFF_CMD, 32'h00000010);
        rdc(OFF_FLAGS, 32'h00000001, 32'h00000005);
        wr(OFF_STS, 32'h00000003);
        wr(OFF_DEST, 32'h00000055);
        wr(OFF_SRC1, 32'hffffffff);
        wr(OFF_CMD, 32'h00000010);
        rdc(OFF_DEST, 32'h00000055);
        rdc(OFF_STS, 32'h00000002);
    endtask : t_sqrt
    task automatic t_incdec;
        wr(OFF_STS, 32'h00000003);
        wr(OFF_DEST, INT_MIN);
        wr(OFF_CMD, 32'h00000012);
        rdc(OFF_DEST, 32'h7fffffff);
        wr(OFF_CMD, 32'h00000011);
        rdc(OFF_DEST, 32'h80000000);
        wr(OFF_STS, 32'h00000003);
        wr(OFF_CMD, 32'h0000c731);
        rdc(OFF_STS, 32'h00000002);
        rdc(OFF_DEST, 32'h80000000);
        wr(OFF_STS, 32'h00000003);
        wr(OFF_CMD, 32'h0000c831);
        wr(OFF_CMD, 32'h0000ff31);
        rdc(OFF_DEST, 32'h80000002);
        rdc(OFF_STS, 32'h00000001);
    endtask : t_incdec
    task automatic t_absneg;
        wr(OFF_SRC1, 32'hfffe7960);
        wr(OFF_CMD, 32'h00000013);
        rdc(OFF_DEST, 32'h000186a0);
        rdc(OFF_FLAGS, 32'h00000000, 32'h00000007);
        wr(OFF_SRC1, 32'h000186a0);
        wr(OFF_CMD, 32'h00000014);
        rdc(OFF_DEST, 32'hfffe7960);
        wr(OFF_STS, 32'h00000003);
        wr(OFF_SRC1, INT_MIN);
        wr(OFF_CMD, 32'h00000013);
        rdc(OFF_STS, 32'h00000002);
        wr(OFF_STS, 32'h00000003);
        wr(OFF_CMD, 32'h00000014);
        rdc(OFF_STS, 32'h00000002);
        rdc(OFF_DEST, 32'hfffe7960);
    endtask : t_absneg
    task automatic t_float;
        fop(32'h00000017, 32'h3fc00000, 32'h40100000, 32'h40700000, 32'h00000000);
        fop(32'h00000018, 32'h3fc00000, 32'h40100000, 32'hbf400000, 32'h00000000);
        fop(32'h00000018, 32'h3fc00000, 32'h3fc00000, 32'h00000000, 32'h00000001);
        fop(32'h00000017, 32'h3f800000, 32'h33800000, 32'h3f800000, 32'h00000000);
        fop(32'h00000017, 32'h7f000000, 32'h7f000000, 32'h7f800000, 32'h00000002);
    endtask : t_float
    // carry is left set by the float overflow so the sum must clear it
    task automatic t_sum;
        logic [15:0] u16 [5];
        int i;
        u16 = '{16'h03e8, 16'h07d0, 16'h0bb8, 16'h0fa0, 16'hec78};
        wr(OFF_STS, 32'h00000003);
        wr(OFF_MSK, 32'h00000001);
        for (i = 0; i < 5; i++) begin
            wr(OFF_MEM + 12'(4 * i), {16'h0000, u16[i]});
        end
        wr(OFF_SRC1, 32'h00000000);
        wr(OFF_SRC2, 32'h00000005);
        wr(OFF_CMD, 32'h00000015);
        waitsum();
        rdc(OFF_DEST, 32'h00001388);
        rdc(OFF_FLAGS, 32'h00000000, 32'h00000007);
        irqchk(1'b1);
        wr(OFF_STS, 32'h00000001);
        irqchk(1'b0);
        wr(OFF_SRC2, 32'h000000ff);
        wr(OFF_CMD, 32'h00000015);
        waitsum();
        rdc(OFF_DEST, 32'h00004e20);
        wr(OFF_SRC2, 32'h00000000);
        wr(OFF_CMD, 32'h00000015);
        waitsum();
        rdc(OFF_FLAGS, 32'h00000001, 32'h00000007);
        wr(OFF_STS, 32'h00000003);
        wr(OFF_SRC2, 32'h00000100);
        wr(OFF_CMD, 32'h00000015);
        rdc(OFF_STS, 32'h00000002);
        wr(OFF_MEM, 32'hffff0d40);
        wr(OFF_MEM + 12'h004, 32'h00000003);
        wr(OFF_MEM + 12'h008, 32'h000093e0);
        wr(OFF_MEM + 12'h00c, 32'h00000004);
        rdc(OFF_MEM, 32'h00000d40);
        wr(OFF_SRC2, 32'h00000002);
        wr(OFF_CMD, 32'h00000016);
        waitsum();
        rdc(OFF_DEST, 32'h0007a120);
        wr(OFF_STS, 32'h00000003);
        wr(OFF_SRC2, 32'hffffffff);
        wr(OFF_CMD, 32'h00000016);
        rdc(OFF_STS, 32'h00000002);
        rdc(OFF_DEST, 32'h0007a120);
    endtask : t_sum
    task automatic t_bus;
        wr(OFF_MSK, 32'h00000000);
        irqchk(1'b0);
        wr(OFF_MSK, 32'h00000002);
        irqchk(1'b1);
        u_dar_seq_model.xfer(1'b0, 12'h01c, 32'h00000000);
        chk({31'h0, u_dar_seq_model.rerr}, 32'h00000001);
        chk(u_dar_seq_model.rdata, 32'h00000000);
        wr(OFF_STS, 32'h00000002);
        irqchk(1'b0);
    endtask : t_bus
    // ****************
    // verdict, run order and watchdog
    // ****************
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_sqrt();
        t_incdec();
        t_absneg();
        t_float();
        t_sum();
        t_bus();
        print_verdict();
    end
    // whole run is under a thousand cycles; this bound only cuts a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        print_verdict();
    end
endmodule : dar_unit_tb_top
`default_nettype wire

// [hdl/dar_unit.sv]
// double-integer and real arithmetic unit with apb register access
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`default_nettype none
module dar_unit
    import dar_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire dar_apb_req_t apb_req,
    output dar_apb_rsp_t apb_rsp,
    output logic irq
);
    // ****************
    // helpers
    // ****************
    function automatic dar_sel_t sel_of(input logic [11:0] a);
        if (a == OFF_CMD) begin
            return SEL_CMD;
        end else if (a == OFF_SRC1) begin
            return SEL_SRC1;
        end else if (a == OFF_SRC2) begin
            return SEL_SRC2;
        end else if (a == OFF_DEST) begin
            return SEL_DEST;
        end else if (a == OFF_FLAGS) begin
            return SEL_FLAGS;
        end else if (a == OFF_STS) begin
            return SEL_STS;
        end else if (a == OFF_MSK) begin
            return SEL_MSK;
        end else if (a[11:8] == OFF_MEM[11:8]) begin
            return SEL_MEM;
        end else begin
            return SEL_NONE;
        end
    endfunction : sel_of

    // digit-by-digit root; bit 16 flags a nonzero remainder
    function automatic logic [16:0] isqrt(input logic [31:0] a);
        logic [17:0] rem;
        logic [17:0] trial;
        logic [15:0] root;
        rem = '0;
        root = '0;
        for (int i = 15; i >= 0; i--) begin
            rem = {rem[15:0], a[2*i+:2]};
            trial = {root, 2'b01};
            if (rem >= trial) begin
                rem = rem - trial;
                root = {root[14:0], 1'b1};
            end else begin
                root = {root[14:0], 1'b0};
            end
        end
        return {rem != 18'h0, root};
    endfunction : isqrt

    // single-precision add; returns {over_limit, zero, result}; subnormals flush to zero
    function automatic logic [33:0] fadd(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] x;
        logic [31:0] y;
        logic [26:0] mx;
        logic [26:0] my;
        logic [26:0] ms;
        logic [27:0] s;
        logic [24:0] m;
        logic [8:0] e;
        logic [7:0] d;
        logic ovf;
        if (b[30:0] > a[30:0]) begin
            x = b;
            y = a;
        end else begin
            x = a;
            y = b;
        end
        mx = (x[30:23] == 8'h0) ? 27'h0 : {1'b1, x[22:0], 3'b000};
        my = (y[30:23] == 8'h0) ? 27'h0 : {1'b1, y[22:0], 3'b000};
        d = x[30:23] - y[30:23];
        if (d >= 8'h1b) begin
            ms = {26'h0, |my};
        end else begin
            ms = (my >> d) | {26'h0, |(my & ((27'h1 << d) - 27'h1))};
        end
        s = (x[31] == y[31]) ? {1'b0, mx} + {1'b0, ms} : {1'b0, mx} - {1'b0, ms};
        e = {1'b0, x[30:23]};
        if (s[27]) begin
            s = {1'b0, s[27:2], s[1] | s[0]};
            e = e + 9'h1;
        end
        for (int i = 0; i < 26; i++) begin
            if (!s[26] && e > 9'h1) begin
                s = {s[26:0], 1'b0};
                e = e - 9'h1;
            end
        end
        // round to nearest, ties to even
        m = {1'b0, s[26:3]};
        if (s[2] && (s[1] || s[0] || s[3])) begin
            m = m + 25'h1;
        end
        if (m[24]) begin
            m = {1'b0, m[24:1]};
            e = e + 9'h1;
        end
        if (!s[26]) begin
            return {2'b01, 32'h0};
        end
        ovf = (e > FP_EXP_LIM) || (e == FP_EXP_LIM && m[22:0] != 23'h0);
        if (e > FP_EXP_LIM) begin
            return {2'b10, x[31], 8'hff, 23'h0};
        end
        return {ovf, 1'b0, x[31], e[7:0], m[22:0]};
    endfunction : fadd

    // ****************
    // state and next state
    // ****************
    dar_state_t s_ff;
    dar_state_t nxt_s;
    dar_sel_t sel;
    logic wr;
    logic go;
    logic err;
    logic done;
    logic [1:0] clr;
    dar_op_t op;
    logic [16:0] rt;
    logic [33:0] fr;
    logic [31:0] word;

    always_comb begin
        nxt_s = s_ff;
        sel = sel_of(apb_req.paddr);
        wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
        go = wr && sel == SEL_CMD && apb_req.pwdata[CMD_EN_BIT] && s_ff.fsm == ST_IDLE;
        op = dar_op_t'(apb_req.pwdata[3:0]);
        err = 1'b0;
        done = 1'b0;
        clr = 2'b00;
        rt = isqrt(s_ff.src1);
        fr = fadd(s_ff.src1, {s_ff.src2[31] ^ (op == OP_FSUB), s_ff.src2[30:0]});
        word = {s_ff.mem[s_ff.ptr + 6'h1], s_ff.mem[s_ff.ptr]};
        // register reads are captured in the setup cycle so prdata is a flop
        if (apb_req.psel && !apb_req.penable) begin
            case (sel)
                SEL_CMD: nxt_s.prdata = {16'h0, s_ff.cmd};
                SEL_SRC1: nxt_s.prdata = s_ff.src1;
                SEL_SRC2: nxt_s.prdata = s_ff.src2;
                SEL_DEST: nxt_s.prdata = s_ff.dest;
                SEL_FLAGS: nxt_s.prdata = {28'h0, s_ff.fsm == ST_SUM, s_ff.borrow, s_ff.carry, s_ff.zero};
                SEL_STS: nxt_s.prdata = {30'h0, s_ff.sts};
                SEL_MSK: nxt_s.prdata = {30'h0, s_ff.msk};
                SEL_MEM: nxt_s.prdata = {16'h0, s_ff.mem[apb_req.paddr[7:2]]};
                default: nxt_s.prdata = RST_WORD;
            endcase
        end
        if (wr) begin
            case (sel)
                SEL_SRC1: nxt_s.src1 = apb_req.pwdata;
                SEL_SRC2: nxt_s.src2 = apb_req.pwdata;
                SEL_DEST: nxt_s.dest = (s_ff.fsm == ST_IDLE) ? apb_req.pwdata : s_ff.dest;
                SEL_STS: clr = apb_req.pwdata[1:0];
                SEL_MSK: nxt_s.msk = apb_req.pwdata[1:0];
                SEL_MEM: nxt_s.mem[apb_req.paddr[7:2]] = apb_req.pwdata[15:0];
                default: nxt_s.cmd = s_ff.cmd;
            endcase
        end
        if (go) begin
            nxt_s.cmd = apb_req.pwdata[15:0];
            done = 1'b1;
            case (op)
                OP_SQRT: begin
                    if (s_ff.src1[31]) begin
                        err = 1'b1;
                    end else begin
                        nxt_s.dest = {16'h0, rt[15:0]};
                        nxt_s.zero = rt[15:0] == 16'h0;
                        nxt_s.borrow = rt[16];
                    end
                end
                OP_INC: begin
                    if (apb_req.pwdata[CMD_CTR_BIT] && apb_req.pwdata[CMD_IDX_LSB+:8] < CTR_MIN) begin
                        err = 1'b1;
                    end else begin
                        nxt_s.dest = s_ff.dest + 32'h1;
                    end
                end
                OP_DEC: nxt_s.dest = s_ff.dest - 32'h1;
                OP_ABS, OP_NEG: begin
                    if (s_ff.src1 == INT_MIN) begin
                        err = 1'b1;
                    end else begin
                        nxt_s.dest = (op == OP_NEG || s_ff.src1[31]) ? -s_ff.src1 : s_ff.src1;
                        nxt_s.zero = s_ff.src1 == 32'h0;
                        nxt_s.carry = 1'b0;
                        nxt_s.borrow = 1'b0;
                    end
                end
                OP_SUM16, OP_SUM32: begin
                    if (s_ff.src2 > CNT_MAX) begin
                        err = 1'b1;
                    end else begin
                        // every block sum holds the unit busy, even with count 0; completion is signalled from the loop
                        done = 1'b0;
                        nxt_s.fsm = ST_SUM;
                        nxt_s.acc = RST_WORD;
                        nxt_s.left = s_ff.src2[7:0];
                        nxt_s.ptr = s_ff.src1[5:0];
                    end
                end
                OP_FADD, OP_FSUB: begin
                    nxt_s.dest = fr[31:0];
                    nxt_s.carry = fr[33];
                    nxt_s.zero = fr[32];
                end
                default: err = 1'b1;
            endcase
        end
        // ****************
        // block sum loop, one value per cycle
        // ****************
        case (s_ff.fsm)
            ST_SUM: begin
                if (s_ff.left == 8'h0) begin
                    nxt_s.fsm = ST_IDLE;
                    nxt_s.dest = s_ff.acc;
                    nxt_s.zero = s_ff.acc == 32'h0;
                    nxt_s.carry = 1'b0;
                    nxt_s.borrow = 1'b0;
                    done = 1'b1;
                end else if (s_ff.cmd[3:0] == OP_SUM32) begin
                    nxt_s.acc = s_ff.acc + word;
                    nxt_s.ptr = s_ff.ptr + 6'h2;
                    nxt_s.left = s_ff.left - 8'h1;
                end else begin
                    nxt_s.acc = s_ff.acc + {{16{word[15]}}, word[15:0]};
                    nxt_s.ptr = s_ff.ptr + 6'h1;
                    nxt_s.left = s_ff.left - 8'h1;
                end
            end
            default: nxt_s.fsm = nxt_s.fsm;
        endcase
        // sticky events: a set in the clearing cycle wins
        nxt_s.sts = (s_ff.sts & ~clr) | {err, done & ~err};
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************
    // outputs
    // ****************
    assign apb_rsp.prdata = s_ff.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && sel == SEL_NONE;
    assign irq = |(s_ff.sts & s_ff.msk);

    // ****************
    // checks
    // ****************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_sum_go;
        go && (op == OP_SUM16 || op == OP_SUM32) && s_ff.src2 <= CNT_MAX;
    endsequence
    sequence s_sum_end;
        s_ff.fsm == ST_SUM && s_ff.left == 8'h0;
    endsequence

    a_sqrt_neg_err: assert property (go && op == OP_SQRT && s_ff.src1[31] |=> s_ff.sts[STS_ERR] && $stable(s_ff.dest)) else $error("negative root not refused");
    a_sqrt_flags: assert property (go && op == OP_SQRT && !s_ff.src1[31] |=> s_ff.zero == (s_ff.dest == 32'h0) && s_ff.dest[31:16] == 16'h0) else $error("root flags wrong");
    a_inc_wrap: assert property (go && op == OP_INC && !apb_req.pwdata[CMD_CTR_BIT] |=> s_ff.dest == $past(s_ff.dest) + 32'h1) else $error("increment wrong");
    a_ctr_range: assert property (go && op == OP_INC && apb_req.pwdata[CMD_CTR_BIT] && apb_req.pwdata[15:8] < CTR_MIN |=> s_ff.sts[STS_ERR] && $stable(s_ff.dest)) else $error("counter range");
    a_dec_wrap: assert property (go && op == OP_DEC |=> s_ff.dest == $past(s_ff.dest) - 32'h1) else $error("decrement wrong");
    a_abs_value: assert property (go && op == OP_ABS && s_ff.src1 != INT_MIN |=> !s_ff.dest[31]) else $error("magnitude negative");
    a_neg_minerr: assert property (go && op == OP_NEG && s_ff.src1 == INT_MIN |=> s_ff.sts[STS_ERR] && $stable(s_ff.dest)) else $error("negate min");
    a_cnt_range: assert property (go && (op == OP_SUM16 || op == OP_SUM32) && s_ff.src2 > CNT_MAX |=> s_ff.fsm == ST_IDLE && s_ff.sts[STS_ERR]) else $error("count range");
    a_sum_finish: assert property (s_sum_go |-> ##[1:257] s_sum_end ##1 (!s_ff.carry && !s_ff.borrow && s_ff.sts[STS_DONE])) else $error("sum end");
    a_fadd_zero: assert property (go && op == OP_FADD && s_ff.src1 == {~s_ff.src2[31], s_ff.src2[30:0]} |=> s_ff.zero && !s_ff.carry) else $error("float zero");

    // ****************
    // step checks
    // ****************
    // one pass of the sum loop, taken while values are still left
    sequence s_sum_step;
        s_ff.fsm == ST_SUM && s_ff.left != 8'h0;
    endsequence
    // a root request on a source that is not negative
    sequence s_root_go;
        go && op == OP_SQRT && !s_ff.src1[31];
    endsequence

    a_abs_minerr: assert property (
        go && op == OP_ABS && s_ff.src1 == INT_MIN
        |=> s_ff.sts[STS_ERR] && $stable(s_ff.dest)
    ) else $error("abs of minimum not refused");

    a_neg_value: assert property (
        go && op == OP_NEG && s_ff.src1 != INT_MIN
        |=> s_ff.dest == -$past(s_ff.src1)
    ) else $error("negate value wrong");

    a_abs_flags: assert property (
        go && op == OP_ABS && s_ff.src1 != INT_MIN
        |=> !s_ff.carry && !s_ff.borrow
    ) else $error("abs flags not cleared");

    // squared root may not exceed the source
    a_root_under: assert property (
        s_root_go
        |=> {16'h0, s_ff.dest[15:0]} * {16'h0, s_ff.dest[15:0]} <= $past(s_ff.src1)
    ) else $error("root too large");

    // borrow marks exactly the sources that are not perfect squares
    a_root_borrow: assert property (
        s_root_go
        |=> s_ff.borrow == ($past(s_ff.src1) != {16'h0, s_ff.dest[15:0]} * {16'h0, s_ff.dest[15:0]})
    ) else $error("root borrow wrong");

    a_fsub_zero: assert property (
        go && op == OP_FSUB && s_ff.src1 == s_ff.src2 && s_ff.src1[30:23] != 8'h0
        |=> s_ff.zero && s_ff.dest == 32'h0
    ) else $error("self subtract not zero");

    a_sum_start: assert property (
        s_sum_go
        |=> s_ff.fsm == ST_SUM && s_ff.left == $past(s_ff.src2[7:0])
    ) else $error("sum not started");

    a_sum_count: assert property (
        s_sum_step
        |=> s_ff.fsm == ST_SUM && s_ff.left == $past(s_ff.left) - 8'h1
    ) else $error("sum count step wrong");

    // flags after a sum follow the stored total only
    a_sum_flags: assert property (
        s_sum_end
        |=> !s_ff.carry && !s_ff.borrow && s_ff.zero == (s_ff.dest == 32'h0)
    ) else $error("sum flags wrong");

    a_ctr_accept: assert property (
        go && op == OP_INC && apb_req.pwdata[CMD_CTR_BIT] && apb_req.pwdata[15:8] >= CTR_MIN
        |=> s_ff.dest == $past(s_ff.dest) + 32'h1
    ) else $error("valid counter refused");

    // decrement must leave every flag alone
    a_dec_flags: assert property (
        go && op == OP_DEC
        |=> $stable(s_ff.zero) && $stable(s_ff.carry) && $stable(s_ff.borrow)
    ) else $error("decrement touched flags");
endmodule : dar_unit
`default_nettype wire

// [shared/dar_pkg.sv]
// constants, types and layouts of the double-integer and real arithmetic unit
//
// How it works
// - while enabled, square root writes integer root of 32-bit source, fraction dropped
// - square root sets zero on zero result, borrow when a fraction was dropped
// - negative square-root source gives operand error, destination left unchanged
// - increment adds one each enable, wrapping maximum to minimum
// - counter destination of increment accepted only for counters 200 to 255
// - decrement subtracts one each enable, wrapping minimum to maximum
// - absolute value writes magnitude; most negative source is an operand error
// - negation writes two's complement; most negative source is an operand error
// - 16-bit block sum adds counted signed units from start, 32-bit total
// - 16-bit block sum count outside 0 to 255 is an operand error
// - 16-bit block sum clears carry and borrow, zero follows final total
// - 32-bit block sum adds counted two-unit values from start into destination
// - 32-bit block sum count outside 0 to 255 is an operand error
// - while enabled, float add writes sum of both float sources
// - float add and subtract set carry above 2^127 magnitude, zero on zero
// - while enabled, float subtract writes first source minus second
`default_nettype none
package dar_pkg;
    // ****************
    // register map
    // ****************
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFF_CMD = 12'h000;
    localparam logic [11:0] OFF_SRC1 = 12'h004;
    localparam logic [11:0] OFF_SRC2 = 12'h008;
    localparam logic [11:0] OFF_DEST = 12'h00c;
    localparam logic [11:0] OFF_FLAGS = 12'h010;
    localparam logic [11:0] OFF_STS = 12'h014;
    localparam logic [11:0] OFF_MSK = 12'h018;
    localparam logic [11:0] OFF_MEM = 12'h100;
    localparam int unsigned MEM_UNITS = 64;
    localparam int unsigned IDX_W = 6;
    // ****************
    // field layouts
    // ****************
    localparam int unsigned CMD_EN_BIT = 4;
    localparam int unsigned CMD_CTR_BIT = 5;
    localparam int unsigned CMD_IDX_LSB = 8;
    localparam int unsigned STS_DONE = 0;
    localparam int unsigned STS_ERR = 1;
    // ****************
    // limits and reset values
    // ****************
    localparam logic [31:0] CNT_MAX = 32'h000000ff;
    localparam logic [7:0] CTR_MIN = 8'hc8;
    localparam logic [31:0] INT_MIN = 32'h80000000;
    localparam logic [8:0] FP_EXP_LIM = 9'h0fe;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    // ****************
    // types
    // ****************
    typedef enum logic [3:0] {
        OP_SQRT, OP_INC, OP_DEC, OP_ABS, OP_NEG, OP_SUM16, OP_SUM32, OP_FADD, OP_FSUB
    } dar_op_t;
    typedef enum logic {ST_IDLE, ST_SUM} dar_fsm_t;
    typedef enum logic [3:0] {
        SEL_CMD, SEL_SRC1, SEL_SRC2, SEL_DEST, SEL_FLAGS, SEL_STS, SEL_MSK, SEL_MEM, SEL_NONE
    } dar_sel_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dar_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dar_apb_rsp_t;
    typedef struct packed {
        dar_fsm_t fsm;
        logic [15:0] cmd;
        logic [31:0] src1;
        logic [31:0] src2;
        logic [31:0] dest;
        logic [31:0] acc;
        logic [7:0] left;
        logic [5:0] ptr;
        logic zero;
        logic carry;
        logic borrow;
        logic [1:0] sts;
        logic [1:0] msk;
        logic [31:0] prdata;
        logic [63:0][15:0] mem;
    } dar_state_t;
endpackage : dar_pkg
`default_nettype wire
